// *** core/erit_timer.sv ***
// Purpose: Eight-bit up-counting timer with interval and auto-reload modes behind APB.
// Assumes: Single clock; prescaler taps are free-running counters in this clock domain.
// Notes: Watch clock arrives as a one-cycle enable pulse per watch tick.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps

// How it works
// - Mode bit 7 picks interval or reload
// - Mode bit 6 runs or stops counter
// - Mode bits 5..3 read one, ignore writes
// - Bits 2..0 pick one of eight taps
// - Counter advances by one per selected tap
// - Overflow after 0xff sets request flag
// - Flag and enable raise interrupt request
// - Interval mode wraps counter to zero
// - Load write also copies into counter
// - Reload mode reloads counter on overflow
// - Shared address: read counter, write load
// - Reset clears counter, load, mode bit
// - Power mode gates system and watch taps
// - Standby wait gates all taps, sub wait gates system taps only
module erit_timer (
  input wire logic ref_clk_i, // System clock.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic watch_tick_i, // One-cycle pulse per watch clock period.
  input wire logic [2:0] pwr_mode_i, // Current power mode code.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq_o // Overflow interrupt request.
);
  logic [1:0] mode_ctrl_q;
  logic [2:0] cksel_q;
  logic [7:0] count_q;
  logic [7:0] reload_q;
  logic irq_stat_q;
  logic irq_mask_q;
  logic [erit_pkg::SYS_PRESC_W-1:0] sys_presc_q;
  logic [erit_pkg::WATCH_PRESC_W-1:0] watch_presc_q;
  logic [erit_pkg::SYS_PRESC_W-1:0] sys_presc_d;
  logic [erit_pkg::WATCH_PRESC_W-1:0] watch_presc_d;
  logic tap_hit;
  logic sys_ok;
  logic watch_ok;
  logic count_step;
  logic overflow;
  logic acc;
  logic wr;
  logic mapped;
  logic [7:0] mode_rd;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == erit_pkg::OFS_MODE) || (paddr == erit_pkg::OFS_COUNT) ||
                  (paddr == erit_pkg::OFS_IRQ_STAT) || (paddr == erit_pkg::OFS_IRQ_MASK);
  assign pslverr = acc && !mapped;
  assign mode_rd = {mode_ctrl_q, erit_pkg::MODE_RSVD_VAL, cksel_q};

  // Free-running prescalers; watch prescaler only moves on watch ticks.
  assign sys_presc_d = sys_presc_q + 1'b1;
  assign watch_presc_d = watch_presc_q + 1'b1;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      sys_presc_q <= '0;
      watch_presc_q <= '0;
    end
    else
    begin
      sys_presc_q <= sys_presc_d;
      if (watch_tick_i)
      begin
        watch_presc_q <= watch_presc_d;
      end
    end
  end

  // A tap fires when all lower prescaler bits roll over on this step.
  always_comb
  begin
    unique case (cksel_q)
      3'b000: tap_hit = &sys_presc_q[12:0];
      3'b001: tap_hit = &sys_presc_q[10:0];
      3'b010: tap_hit = &sys_presc_q[7:0];
      3'b011: tap_hit = &sys_presc_q[5:0];
      3'b100: tap_hit = &sys_presc_q[3:0];
      3'b101: tap_hit = &sys_presc_q[1:0];
      3'b110: tap_hit = watch_tick_i && (&watch_presc_q[9:0]);
      3'b111: tap_hit = watch_tick_i && (&watch_presc_q[7:0]);
    endcase
  end

  // Taps from the system prescaler count only in active and sleep.
  assign sys_ok = (pwr_mode_i == erit_pkg::ERIT_PWR_ACTIVE) ||
                  (pwr_mode_i == erit_pkg::ERIT_PWR_SLEEP);
  // Watch taps stop only in standby and in the wait leaving standby.
  assign watch_ok = (pwr_mode_i != erit_pkg::ERIT_PWR_STANDBY) &&
                    (pwr_mode_i != erit_pkg::ERIT_PWR_WAIT_STBY);
  assign count_step = mode_ctrl_q[0] && tap_hit && (cksel_q[2] && cksel_q[1] ? watch_ok : sys_ok);
  assign overflow = count_step && (count_q == erit_pkg::COUNT_MAX);

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      mode_ctrl_q <= erit_pkg::MODE_CTRL_RST;
      cksel_q <= erit_pkg::CKSEL_RST;
    end
    else if (wr && paddr == erit_pkg::OFS_MODE)
    begin
      mode_ctrl_q <= pwdata[erit_pkg::MODE_RELOAD_BIT:erit_pkg::MODE_RUN_BIT];
      cksel_q <= pwdata[2:0];
    end
  end

  // Software is expected to stop the counter before touching settings.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      reload_q <= erit_pkg::RELOAD_RST;
    end
    else if (wr && paddr == erit_pkg::OFS_COUNT)
    begin
      reload_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      count_q <= erit_pkg::COUNT_RST;
    end
    else if (wr && paddr == erit_pkg::OFS_COUNT)
    begin
      count_q <= pwdata[7:0];
    end
    else if (overflow)
    begin
      count_q <= mode_ctrl_q[1] ? reload_q : erit_pkg::COUNT_RST;
    end
    else if (count_step)
    begin
      count_q <= count_q + 8'h01;
    end
  end

  // Sticky overflow flag; a new overflow wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      irq_stat_q <= 1'b0;
    end
    else if (overflow)
    begin
      irq_stat_q <= 1'b1;
    end
    else if (wr && paddr == erit_pkg::OFS_IRQ_STAT && pwdata[0])
    begin
      irq_stat_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      irq_mask_q <= 1'b0;
    end
    else if (wr && paddr == erit_pkg::OFS_IRQ_MASK)
    begin
      irq_mask_q <= pwdata[0];
    end
  end

  assign irq_o = irq_stat_q && irq_mask_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        erit_pkg::OFS_MODE: prdata <= {24'h000000, mode_rd};
        erit_pkg::OFS_COUNT: prdata <= {24'h000000, count_q};
        erit_pkg::OFS_IRQ_STAT: prdata <= {31'h00000000, irq_stat_q};
        erit_pkg::OFS_IRQ_MASK: prdata <= {31'h00000000, irq_mask_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  a_ovf_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    overflow |=> irq_stat_q) else $error("overflow did not set flag");
  a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    irq_o == (irq_stat_q && irq_mask_q)) else $error("irq mismatch");
  a_wrap_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    overflow && !mode_ctrl_q[1] && !(wr && paddr == erit_pkg::OFS_COUNT) |=> count_q == 8'h00)
    else $error("interval wrap wrong");
  a_reload_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    overflow && mode_ctrl_q[1] && !(wr && paddr == erit_pkg::OFS_COUNT) |=> count_q == $past(reload_q))
    else $error("reload wrong");
  a_load_copies: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr && paddr == erit_pkg::OFS_COUNT |=> count_q == $past(pwdata[7:0]) && reload_q == count_q)
    else $error("load copy wrong");
  a_stopped_holds: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !mode_ctrl_q[0] && !wr |=> $stable(count_q)) else $error("stopped counter moved");
  a_rsvd_ones: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    psel && !penable && !pwrite && paddr == erit_pkg::OFS_MODE |=> prdata[5:3] == 3'h7)
    else $error("reserved bits not one");
  a_standby_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pwr_mode_i == erit_pkg::ERIT_PWR_STANDBY && !wr |=> $stable(count_q)) else $error("counted in standby");
  a_wait_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pwr_mode_i == erit_pkg::ERIT_PWR_WAIT_SUB && !(cksel_q[2] && cksel_q[1]) |-> !count_step)
    else $error("system tap counted in wait");
  a_step_one: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    count_step && !overflow && !wr |=> count_q == $past(count_q) + 8'h01) else $error("bad increment");
  a_reset_vals: assert property (@(posedge ref_clk_i)
    !nrst_i |=> count_q == 8'h00 && reload_q == 8'h00 && !mode_ctrl_q[1]) else $error("reset values");

  // Bus steps that several properties start from.
  sequence s_mode_write;
    wr && paddr == erit_pkg::OFS_MODE;
  endsequence

  sequence s_load_write;
    wr && paddr == erit_pkg::OFS_COUNT;
  endsequence

  sequence s_mask_write;
    wr && paddr == erit_pkg::OFS_IRQ_MASK;
  endsequence

  sequence s_mode_read;
    psel && !penable && !pwrite && paddr == erit_pkg::OFS_MODE;
  endsequence

  sequence s_count_read;
    psel && !penable && !pwrite && paddr == erit_pkg::OFS_COUNT;
  endsequence

  sequence s_stat_read;
    psel && !penable && !pwrite && paddr == erit_pkg::OFS_IRQ_STAT;
  endsequence

  // Mode register fields take the written bits and hold otherwise.
  a_mode_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_mode_write |=> mode_ctrl_q == $past(pwdata[7:6]))
    else $error("mode bits not written");

  a_cksel_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_mode_write |=> cksel_q == $past(pwdata[2:0]))
    else $error("clock select not written");

  a_mode_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !(wr && paddr == erit_pkg::OFS_MODE) |=> $stable(mode_ctrl_q) && $stable(cksel_q))
    else $error("mode changed without write");

  a_mode_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_mode_read |=> prdata[7:0] == {$past(mode_ctrl_q), 3'h7, $past(cksel_q)})
    else $error("mode read wrong");

  // Shared address: reads see the counter, writes go to the load value.
  a_load_reload: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_load_write |=> reload_q == $past(pwdata[7:0]))
    else $error("load value not stored");

  a_reload_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !(wr && paddr == erit_pkg::OFS_COUNT) |=> $stable(reload_q))
    else $error("load value changed");

  a_count_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_count_read |=> prdata == {24'h000000, $past(count_q)})
    else $error("counter read wrong");

  a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  a_slverr_map: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pslverr == (acc && !mapped))
    else $error("error response wrong");

  a_pready_high: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pready)
    else $error("ready low");

  // Counting only moves on a selected tap.
  a_no_step_stop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !mode_ctrl_q[0] |-> !count_step)
    else $error("step while stopped");

  a_count_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !count_step && !(wr && paddr == erit_pkg::OFS_COUNT) |=> $stable(count_q))
    else $error("counter moved without tap");

  a_tap_fast: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cksel_q == 3'b101 && mode_ctrl_q[0] && pwr_mode_i == erit_pkg::ERIT_PWR_ACTIVE && (&sys_presc_q[1:0])
    |-> count_step) else $error("fast tap missed");

  a_sys_slow: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cksel_q == 3'b000 && !(&sys_presc_q[12:0]) |-> !count_step)
    else $error("slow tap too early");

  a_sys_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !sys_ok && !(cksel_q[2] && cksel_q[1]) |-> !count_step)
    else $error("system tap counted while gated");

  a_watch_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cksel_q[2] && cksel_q[1]) && !watch_ok |-> !count_step)
    else $error("watch tap counted while gated");

  a_watch_sub: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cksel_q == 3'b110 && mode_ctrl_q[0] && pwr_mode_i == erit_pkg::ERIT_PWR_SUBACTIVE && watch_tick_i &&
    (&watch_presc_q[9:0]) |-> count_step) else $error("watch tap missed");

  a_watch_wait: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cksel_q == 3'b111 && mode_ctrl_q[0] && pwr_mode_i == erit_pkg::ERIT_PWR_WAIT_SUB && watch_tick_i &&
    (&watch_presc_q[7:0]) |-> count_step) else $error("watch tap stopped in wait");

  a_presc_steps: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> sys_presc_q == $past(sys_presc_d))
    else $error("system prescaler skipped");

  a_watch_presc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $past(nrst_i) && !$past(watch_tick_i) |-> $stable(watch_presc_q))
    else $error("watch prescaler moved without tick");

  // Overflow and its flag.
  a_ovf_only_ff: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    overflow |-> count_q == erit_pkg::COUNT_MAX)
    else $error("overflow below top");

  a_no_early_ovf: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    count_q != erit_pkg::COUNT_MAX |-> !overflow)
    else $error("early overflow");

  a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    irq_stat_q && !(wr && paddr == erit_pkg::OFS_IRQ_STAT && pwdata[0]) |=> irq_stat_q)
    else $error("flag lost");

  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr && paddr == erit_pkg::OFS_IRQ_STAT && pwdata[0] && !overflow |=> !irq_stat_q)
    else $error("flag not cleared");

  a_flag_only_ovf: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !irq_stat_q && !overflow |=> !irq_stat_q)
    else $error("flag set without overflow");

  a_stat_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_stat_read |=> prdata == {31'h00000000, $past(irq_stat_q)})
    else $error("status read wrong");

  // Interrupt request follows flag and enable.
  a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_mask_write |=> irq_mask_q == $past(pwdata[0]))
    else $error("enable not written");

  a_irq_raise: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    overflow && irq_mask_q && !(wr && paddr == erit_pkg::OFS_IRQ_MASK) |=> irq_o)
    else $error("interrupt not raised");

  a_irq_drop_mask: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr && paddr == erit_pkg::OFS_IRQ_MASK && !pwdata[0] |=> !irq_o)
    else $error("interrupt kept while disabled");

  a_irq_low_noflag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !irq_stat_q |-> !irq_o)
    else $error("interrupt without flag");

  a_reset_rest: assert property (@(posedge ref_clk_i)
    !nrst_i |=> !irq_stat_q && !irq_mask_q && prdata == 32'h0000_0000 && cksel_q == 3'h0)
    else $error("reset state wrong");
endmodule // erit_timer

// *** include/erit_pkg.sv ***
// Purpose: Shared constants for the eight-bit reload interval timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register data sits in the low byte; upper bits read as zero.
package erit_pkg;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_COUNT = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
  localparam int MODE_RELOAD_BIT = 7;
  localparam int MODE_RUN_BIT = 6;
  localparam logic [2:0] MODE_RSVD_VAL = 3'h7;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [1:0] MODE_CTRL_RST = 2'h0;
  localparam logic [2:0] CKSEL_RST = 3'h0;
  localparam int SYS_PRESC_W = 13;
  localparam int WATCH_PRESC_W = 10;
  typedef enum logic [2:0] {
    ERIT_PWR_ACTIVE = 3'b000,
    ERIT_PWR_SLEEP = 3'b001,
    ERIT_PWR_WATCH = 3'b010,
    ERIT_PWR_SUBACTIVE = 3'b011,
    ERIT_PWR_SUBSLEEP = 3'b100,
    ERIT_PWR_STANDBY = 3'b101,
    ERIT_PWR_WAIT_STBY = 3'b110,
    ERIT_PWR_WAIT_SUB = 3'b111
  } erit_pwr_t;
endpackage

// *** dv/erit_tb.sv ***
// Purpose: Self-checking bench for the eight-bit reload interval timer.
// Assumes: APB answers with pready; fastest tests use the divide-by-16 tap.
// Notes: Counters are stopped before every register change.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  logic ref_clk_i, nrst_i, watch_tick_i, psel, penable, pwrite, pready, pslverr, irq_o, err;
  logic [2:0] pwr_mode_i;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int bad_count, samples_checked;
  erit_timer erit_timer_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .watch_tick_i(watch_tick_i),
    .pwr_mode_i(pwr_mode_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq_o !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b1)
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end
  initial
  begin
    {nrst_i, watch_tick_i, psel, penable, pwrite} = 5'h0;
    pwr_mode_i = erit_pkg::ERIT_PWR_ACTIVE;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(erit_pkg::OFS_MODE, 32'h38);
    rd(erit_pkg::OFS_COUNT, 32'h00);
    rd(erit_pkg::OFS_IRQ_STAT, 32'h0);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h07);
    rd(erit_pkg::OFS_MODE, 32'h3f);
    apb(1'b1, erit_pkg::OFS_COUNT, 32'hfe);
    rd(erit_pkg::OFS_COUNT, 32'hfe);
    apb(1'b1, erit_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, erit_pkg::OFS_MODE, 32'hc4);
    wait_irq();
    apb(1'b1, erit_pkg::OFS_MODE, 32'h84);
    rd(erit_pkg::OFS_COUNT, 32'hfe);
    rd(erit_pkg::OFS_IRQ_STAT, 32'h1);
    apb(1'b1, erit_pkg::OFS_IRQ_STAT, 32'h1);
    rd(erit_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK(irq_o, 1'b0)
    apb(1'b1, erit_pkg::OFS_MODE, 32'h04);
    apb(1'b1, erit_pkg::OFS_COUNT, 32'hff);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h44);
    wait_irq();
    apb(1'b1, erit_pkg::OFS_MODE, 32'h04);
    rd(erit_pkg::OFS_COUNT, 32'h00);
    apb(1'b1, erit_pkg::OFS_IRQ_MASK, 32'h0);
    @(posedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    rd(erit_pkg::OFS_IRQ_STAT, 32'h1);
    apb(1'b1, erit_pkg::OFS_IRQ_STAT, 32'h1);
    pwr_mode_i <= erit_pkg::ERIT_PWR_STANDBY;
    apb(1'b1, erit_pkg::OFS_COUNT, 32'h10);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h44);
    repeat (64) @(posedge ref_clk_i);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h04);
    rd(erit_pkg::OFS_COUNT, 32'h10);
    pwr_mode_i <= erit_pkg::ERIT_PWR_WAIT_SUB;
    apb(1'b1, erit_pkg::OFS_MODE, 32'h44);
    repeat (64) @(posedge ref_clk_i);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h04);
    rd(erit_pkg::OFS_COUNT, 32'h10);
    pwr_mode_i <= erit_pkg::ERIT_PWR_WATCH;
    watch_tick_i <= 1'b1;
    apb(1'b1, erit_pkg::OFS_MODE, 32'h47);
    repeat (600) @(posedge ref_clk_i);
    apb(1'b1, erit_pkg::OFS_MODE, 32'h07);
    apb(1'b0, erit_pkg::OFS_COUNT, 32'h0);
    `CHK(rdat[7:0] > 8'h10, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rdat, 32'h0)
    close_out();
  end
endmodule // testbench
